/* hw/aol_consts.vh */
// Purpose: constants for the alarm output line block
// Assumes: 32-bit Avalon-MM register words, byte addresses
// Notes:   offsets are byte addresses of aligned words
`ifndef AOL_CONSTS_VH
`define AOL_CONSTS_VH

`define AOL_OFF_CTRL      8'h00
`define AOL_OFF_CLEAR     8'h04
`define AOL_OFF_STATUS    8'h08
`define AOL_OFF_MAP       8'h0C
`define AOL_OFF_DCFG      8'h10
`define AOL_OFF_DPAT      8'h14
`define AOL_OFF_DMASK     8'h18
`define AOL_OFF_TLIM      8'h1C
`define AOL_OFF_TCNT      8'h20
`define AOL_OFF_DIN       8'h24

`define AOL_CTRL_LATCH    0
`define AOL_CTRL_HIGHPOL  1
`define AOL_CLR_ALL       4
`define AOL_DCFG_EN       0
`define AOL_DCFG_MISM     1
`define AOL_DCFG_TEN      2

`define AOL_CTRL_RST      2'h0
`define AOL_MAP_RST       32'h00000000
`define AOL_UNMAPPED_RD   32'h00000000

`endif

/* hw/aol_alarm_lines.v */
// Function
// - Four alarm lines, each the OR of channels mapped to it.
// - Any channel maps to one line; many channels may share a line.
// - One latched/tracking setting serves all four lines.
// - Factory reset drops all lines; alarm queue is not touched.
// - Latched: set on first alarm, hold until scan start, power or clear.
// - Manual clear allowed any time, reading memory keeps its alarm data.
// - Tracking: line follows the live alarm condition.
// - Tracking: scan start also drops the lines.
// - One shared polarity: active low means 0 is alarm, active high means 1.
// - Factory reset returns polarity to active low.
// - Clear any lines selected by a bit mask, or all four together.
// - Digital alarm when masked input equals, or mismatches, masked pattern.
// - Care-mask bits at 0 are excluded from the compare.
// - Digital and totalizer alarms evaluated always once enabled.
// - Compare starts at lowest channel bit, spans the configured width.
// - Alarm records go to reading memory only while scanning.
// - Scan start wipes reading memory, alarm queue entries stay.
// - Totalizer alarm when count reaches enabled upper limit.
// - Polarity change acts on the pins at once, no glitch filter.
// - Unmapped channels report on line 1.
//
// Purpose: alarm line drive with digital pattern and totalizer alarm sources
// Assumes: analog channel alarm levels arrive synchronous to clk
// Notes:   reading memory and queue live outside; this block gives write strobes

`include "aol_consts.vh"

module aol_alarm_lines #(
	parameter NCH   = 4,
	parameter DW    = 32,
	parameter TW    = 32
)(
	input  wire                 clk,
	input  wire                 rstn,
	input  wire [7:0]           avs_address,
	input  wire                 avs_read,
	input  wire                 avs_write,
	input  wire [31:0]          avs_writedata,
	input  wire [3:0]           avs_byteenable,
	output reg  [31:0]          avs_readdata,
	output reg                  avs_waitrequest,
	input  wire [NCH-1:0]       chan_alarm,
	input  wire [DW-1:0]        din_port,
	input  wire                 scan_start,
	input  wire                 scan_active,
	input  wire                 tot_pulse,
	output reg  [3:0]           alarm_out,
	output reg                  mem_alarm_wr,
	output reg  [1:0]           mem_alarm_src,
	output reg                  queue_alarm_wr,
	output reg  [1:0]           queue_alarm_src
);

	// ****************************************************************
	// Register state
	// ****************************************************************
	reg  [1:0]      ctrl_ff;
	reg  [31:0]     map_ff;
	reg  [2:0]      dcfg_ff;
	reg  [DW-1:0]   dpat_ff;
	reg  [DW-1:0]   dmask_ff;
	reg  [TW-1:0]   tlim_ff;
	reg  [TW-1:0]   tcnt_ff;
	reg  [3:0]      line_ff;
	reg  [3:0]      clr_ff;
	reg             dig_prev_ff;
	reg             tot_prev_ff;
	reg  [DW-1:0]   din_s1_ff;
	reg  [DW-1:0]   din_s2_ff;
	reg  [1:0]      tot_sync_ff;
	reg             tot_seen_ff;
	reg  [3:0]      nxt_line;
	reg  [3:0]      nxt_clr;
	reg  [31:0]     nxt_rd;

	wire            acc  = avs_read | avs_write;
	wire            wr   = avs_write & avs_waitrequest;
	wire            rd   = avs_read & avs_waitrequest;

	// ****************************************************************
	// Alarm sources
	// ****************************************************************
	// Compare runs from bit 0 upward across DW; masked-out bits drop out
	wire            dig_match = ((din_s2_ff ^ dpat_ff) & dmask_ff) == {DW{1'b0}};
	wire            dig_alarm = dcfg_ff[`AOL_DCFG_EN] &
	                            (dcfg_ff[`AOL_DCFG_MISM] ? ~dig_match : dig_match);
	wire            tot_alarm = dcfg_ff[`AOL_DCFG_TEN] & (tcnt_ff >= tlim_ff);

	// Sources: analog channels, then digital and totalizer as two more channels
	wire [NCH+1:0]  src_alarm = {tot_alarm, dig_alarm, chan_alarm};

	// Per-line OR of mapped sources, two map bits per source
	reg  [3:0]      line_req;
	integer         i;
	always @*
	begin
		line_req = 4'h0;
		for (i = 0; i < NCH + 2; i = i + 1)
		begin
			if (src_alarm[i])
				line_req[map_ff[2*i +: 2]] = 1'b1;
		end
	end

	// ****************************************************************
	// Line update
	// ****************************************************************
	always @*
	begin
		nxt_clr = 4'h0;
		if (wr && avs_address == `AOL_OFF_CLEAR && avs_byteenable[0])
			nxt_clr = avs_writedata[`AOL_CLR_ALL] ? 4'hF : avs_writedata[3:0];
		if (ctrl_ff[`AOL_CTRL_LATCH])
		begin
			// Scan start and clear wipe first, a live alarm then sets again
			nxt_line = line_ff;
			if (scan_start)
				nxt_line = 4'h0;
			nxt_line = (nxt_line & ~clr_ff) | line_req;
		end
		else
		begin
			nxt_line = line_req & ~clr_ff;
			if (scan_start)
				nxt_line = 4'h0;
		end
	end

	// ****************************************************************
	// Clocked state
	// ****************************************************************
	always @(posedge clk)
	begin
		din_s1_ff <= din_port;
		din_s2_ff <= din_s1_ff;
		if (!rstn)
		begin
			ctrl_ff         <= `AOL_CTRL_RST;
			map_ff          <= `AOL_MAP_RST;
			dcfg_ff         <= 3'h0;
			dpat_ff         <= {DW{1'b0}};
			dmask_ff        <= {DW{1'b0}};
			tlim_ff         <= {TW{1'b0}};
			tcnt_ff         <= {TW{1'b0}};
			line_ff         <= 4'h0;
			clr_ff          <= 4'h0;
			dig_prev_ff     <= 1'b0;
			tot_prev_ff     <= 1'b0;
			tot_sync_ff     <= 2'h0;
			tot_seen_ff     <= 1'b0;
			alarm_out       <= 4'hF;
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h00000000;
			mem_alarm_wr    <= 1'b0;
			mem_alarm_src   <= 2'h0;
			queue_alarm_wr  <= 1'b0;
			queue_alarm_src <= 2'h0;
		end
		else
		begin
			// One wait cycle per access, then release
			avs_waitrequest <= ~(acc & avs_waitrequest);
			if (rd)
				avs_readdata <= nxt_rd;
			if (wr)
			begin
				case (avs_address)
					`AOL_OFF_CTRL:  ctrl_ff  <= avs_writedata[1:0];
					`AOL_OFF_MAP:   map_ff   <= avs_writedata;
					`AOL_OFF_DCFG:  dcfg_ff  <= avs_writedata[2:0];
					`AOL_OFF_DPAT:  dpat_ff  <= avs_writedata[DW-1:0];
					`AOL_OFF_DMASK: dmask_ff <= avs_writedata[DW-1:0];
					`AOL_OFF_TLIM:  tlim_ff  <= avs_writedata[TW-1:0];
					default:        ;
				endcase
			end
			// Totalizer counts rising edges of its input pin
			tot_sync_ff <= {tot_sync_ff[0], tot_pulse};
			tot_seen_ff <= tot_sync_ff[1];
			if (wr && avs_address == `AOL_OFF_TCNT)
				tcnt_ff <= {TW{1'b0}};
			else if (tot_sync_ff[1] && !tot_seen_ff && tcnt_ff != {TW{1'b1}})
				tcnt_ff <= tcnt_ff + {{(TW-1){1'b0}}, 1'b1};
			clr_ff  <= nxt_clr;
			line_ff <= nxt_line;
			// Pins reflect polarity at once; changing it may flip the pins
			alarm_out <= ctrl_ff[`AOL_CTRL_HIGHPOL] ? nxt_line : ~nxt_line;
			// Records on rising alarm edges; queue always, memory only in a scan
			dig_prev_ff <= dig_alarm;
			tot_prev_ff <= tot_alarm;
			queue_alarm_wr  <= (dig_alarm & ~dig_prev_ff) | (tot_alarm & ~tot_prev_ff);
			queue_alarm_src <= (dig_alarm & ~dig_prev_ff) ? 2'h1 : 2'h2;
			mem_alarm_wr    <= scan_active & ~scan_start &
			                   ((dig_alarm & ~dig_prev_ff) | (tot_alarm & ~tot_prev_ff));
			mem_alarm_src   <= (dig_alarm & ~dig_prev_ff) ? 2'h1 : 2'h2;
		end
	end

	// ****************************************************************
	// Read mux
	// ****************************************************************
	// Upper bits stay zero; a zero-width pad would be illegal at full width
	always @*
	begin
		nxt_rd = 32'h00000000;
		case (avs_address)
			`AOL_OFF_CTRL:   nxt_rd[1:0] = ctrl_ff;
			`AOL_OFF_CLEAR:  nxt_rd = 32'h00000000;
			`AOL_OFF_STATUS: nxt_rd[5:0] = {tot_alarm, dig_alarm, line_ff};
			`AOL_OFF_MAP:    nxt_rd = map_ff;
			`AOL_OFF_DCFG:   nxt_rd[2:0] = dcfg_ff;
			`AOL_OFF_DPAT:   nxt_rd[DW-1:0] = dpat_ff;
			`AOL_OFF_DMASK:  nxt_rd[DW-1:0] = dmask_ff;
			`AOL_OFF_TLIM:   nxt_rd[TW-1:0] = tlim_ff;
			`AOL_OFF_TCNT:   nxt_rd[TW-1:0] = tcnt_ff;
			`AOL_OFF_DIN:    nxt_rd[DW-1:0] = din_s2_ff;
			default:         nxt_rd = `AOL_UNMAPPED_RD;
		endcase
	end

endmodule

/* sim/aol_checker.sv */
// Purpose: port checker for the alarm output line block
// Assumes: digital and totalizer sources idle around scan starts and clears
// Notes:   mode and polarity are mirrored from CTRL writes as they complete
`include "aol_consts.vh"
module aol_checker #(
	parameter NCH = 4
)(
	input logic           clk,
	input logic           rstn,
	input logic [7:0]     avs_address,
	input logic           avs_read,
	input logic           avs_write,
	input logic [31:0]    avs_writedata,
	input logic           avs_waitrequest,
	input logic [NCH-1:0] chan_alarm,
	input logic           scan_start,
	input logic [3:0]     alarm_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] ctl_ff;
	logic [3:0] act;
	// Mirror taken at completion, so it lines up with the pin flip one edge later
	assign act = ctl_ff[1] ? alarm_out : ~alarm_out;
	always @(posedge clk)
		if (!rstn)
			ctl_ff <= 2'h0;
		else if (avs_write && !avs_waitrequest && avs_address == `AOL_OFF_CTRL)
			ctl_ff <= avs_writedata[1:0];
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	a_reset_idle: assert property (disable iff (1'b0) !rstn |=> alarm_out == 4'hF)
		else $error("alarm lines not idle after reset");
	a_bus_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
		else $error("bus access not answered after one wait");
	a_any_line: assert property (|chan_alarm && !scan_start && !$past(avs_write) |=> |act)
		else $error("channel alarm reached no line");
	a_set_wins: assert property (ctl_ff[0] && |chan_alarm |=> |act)
		else $error("live alarm lost in latched mode");
	a_track_scan: assert property (!ctl_ff[0] && scan_start |=> act == 4'h0)
		else $error("scan start did not drop tracking lines");
	a_scan_clears: assert property (scan_start && chan_alarm == 0 |=> act == 4'h0)
		else $error("scan start did not clear lines");
	a_latch_hold: assert property (ctl_ff[0] && !scan_start && !avs_write && !$past(avs_write)
		|=> (act & $past(act)) == $past(act))
		else $error("latched line dropped without clear");
	a_clear_all: assert property (avs_write && !avs_waitrequest && avs_address == `AOL_OFF_CLEAR
		&& avs_writedata[4] ##1 chan_alarm == 0 |=> act == 4'h0)
		else $error("clear all left a line active");
endmodule

/* sim/aol_lamp.sv */
// Purpose: external lamp bank lit by the alarm lines
// Assumes: polarity setting known to the installer
// Notes:   lit is high while a lamp shows alarm
module aol_lamp (
	input  logic [3:0] line,
	input  logic       hi_pol,
	output logic [3:0] lit
);
	timeunit 1ns;
	timeprecision 1ps;
	assign lit = hi_pol ? line : ~line;
endmodule

/* sim/tb_alarm_output_line_control.sv */
// Purpose: self-checking bench for the alarm output line block
// Assumes: one access at a time on the register bus
// Notes:   lamp output is judged, so polarity is checked end to end
`include "aol_consts.vh"
module tb_alarm_output_line_control;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 0, rstn = 0, avs_read = 0, avs_write = 0, scan_start = 0, tot_pulse = 0, pol = 0;
	logic [7:0]  avs_address = 8'h00;
	logic [31:0] avs_writedata = 32'h0, din_port = 32'h0, avs_readdata, q;
	logic [3:0]  avs_byteenable = 4'hF, chan_alarm = 4'h0, alarm_out, lit;
	logic        avs_waitrequest;
	logic        scan_active = 0, q_wr, m_wr;
	logic [1:0]  q_src, m_src, last_qsrc = 2'h0, last_msrc = 2'h0;
	int          nq = 0, nm = 0;
	int          failures = 0, num_checks = 0;
	always #5 clk = ~clk;
	aol_alarm_lines uut (.clk(clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .chan_alarm(chan_alarm),
		.din_port(din_port), .scan_start(scan_start), .scan_active(scan_active), .tot_pulse(tot_pulse),
		.alarm_out(alarm_out), .mem_alarm_wr(m_wr), .mem_alarm_src(m_src), .queue_alarm_wr(q_wr),
		.queue_alarm_src(q_src));
	aol_lamp lamp (.line(alarm_out), .hi_pol(pol), .lit(lit));
	// Record strobes last one cycle, so count them as they pass
	always @(posedge clk)
	begin
		if (q_wr === 1'b1)
		begin
			nq <= nq + 1;
			last_qsrc <= q_src;
		end
		if (m_wr === 1'b1)
		begin
			nm <= nm + 1;
			last_msrc <= m_src;
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Waits for the answer however long it takes; only the watchdog ends a hang
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		do
		begin
			@(posedge clk);
		end
		while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	// Drive channel levels, then give the lines time to settle before judging
	task automatic ln(input logic [3:0] ch, input logic [3:0] exp);
		@(posedge clk);
		chan_alarm <= ch;
		repeat (4) @(posedge clk);
		chk(lit, exp);
	endtask
	task automatic scan();
		@(posedge clk);
		scan_start <= 1'b1;
		@(posedge clk);
		scan_start <= 1'b0;
		@(posedge clk);
		chk(lit, 4'h0);
	endtask
	task automatic t_track();
		bus(0, `AOL_OFF_CTRL, 0); chk(q, 0);
		bus(0, `AOL_OFF_MAP, 0); chk(q, 0);
		bus(0, 8'h3C, 0); chk(q, 0);
		ln(4'h2, 4'h1);
		bus(1, `AOL_OFF_MAP, 32'hA0);
		ln(4'hC, 4'h4);
		ln(4'h8, 4'h4);
		ln(4'h0, 4'h0);
		ln(4'h8, 4'h4);
		scan();
		ln(4'h0, 4'h0);
	endtask
	task automatic t_latch();
		bus(1, `AOL_OFF_CTRL, 1);
		ln(4'h6, 4'h5);
		ln(4'h0, 4'h5);
		bus(1, `AOL_OFF_CLEAR, 32'h1);
		ln(4'h0, 4'h4);
		bus(1, `AOL_OFF_CLEAR, 32'h10);
		ln(4'h1, 4'h1);
		bus(1, `AOL_OFF_CLEAR, 32'h10);
		ln(4'h0, 4'h1);
		scan();
		bus(1, `AOL_OFF_CTRL, 3);
		pol <= 1'b1;
		ln(4'h0, 4'h0); chk(alarm_out, 4'h0);
		ln(4'h1, 4'h1); chk(alarm_out, 4'h1);
		bus(1, `AOL_OFF_CTRL, 0);
		pol <= 1'b0;
		ln(4'h0, 4'h0); chk(alarm_out, 4'hF);
	endtask
	task automatic t_src();
		bus(1, `AOL_OFF_DPAT, 32'hF6);
		bus(1, `AOL_OFF_DMASK, 32'h0F);
		din_port <= 32'hA6;
		bus(1, `AOL_OFF_MAP, 32'h700);
		bus(1, `AOL_OFF_DCFG, 1);
		ln(4'h0, 4'h8);
		bus(0, `AOL_OFF_STATUS, 0); chk(q[4], 1'b1);
		chk(nq, 1);
		chk(nm, 0);
		bus(1, `AOL_OFF_DCFG, 3);
		ln(4'h0, 4'h0);
		scan_active <= 1'b1;
		din_port <= 32'hA7;
		ln(4'h0, 4'h8);
		scan_active <= 1'b0;
		chk(nm, 1);
		chk(last_msrc, 1);
		chk(nq, 2);
		bus(1, `AOL_OFF_TLIM, 2);
		bus(1, `AOL_OFF_DCFG, 4);
		repeat (2)
		begin
			ln(4'h0, 4'h0);
			tot_pulse <= 1'b1;
			repeat (4) @(posedge clk);
			tot_pulse <= 1'b0;
		end
		ln(4'h0, 4'h2);
		chk(nq, 3);
		chk(last_qsrc, 2);
		chk(nm, 1);
		// Mid-run factory reset with line 2 active
		@(posedge clk);
		rstn <= 1'b0;
		@(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		chk(alarm_out, 4'hF);
	endtask
	task automatic final_report();
		$display("checks=%0d failures=%0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial
	begin
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		chk(alarm_out, 4'hF);
		t_track();
		t_latch();
		t_src();
		final_report();
	end
	initial
	begin
		#100000;
		failures++;
		final_report();
	end
endmodule
bind aol_alarm_lines aol_checker #(.NCH(NCH)) chk_i (.clk(clk), .rstn(rstn), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
	.avs_waitrequest(avs_waitrequest), .chan_alarm(chan_alarm), .scan_start(scan_start), .alarm_out(alarm_out));
